// >>> core/psl_pkg.sv
// constants and types for the port status indicator driver
//------------------------------------------------------------
//------------------------------------------------------------
package psl_pkg;
    localparam int NUM_PORTS  = 4;
    localparam int NUM_FUNCS  = 16;
    localparam int NUM_PINS   = 16;
    localparam int STRAP_PINS = 10;
    localparam int HIGH_PIN   = 10;
    localparam int PINS_WIDE  = 4;
    localparam int PINS_NARROW = 2;
    localparam int STREAM_W   = NUM_PORTS * NUM_FUNCS;

    localparam logic [7:0] ADDR_BLINK = 8'h0F;
    localparam logic [7:0] ADDR_FS0   = 8'h10;
    localparam logic [7:0] ADDR_FS1   = 8'h12;
    localparam logic [7:0] ADDR_PSEL  = 8'h14;
    localparam logic [7:0] ADDR_EN    = 8'h16;
    localparam logic [7:0] ADDR_LBA   = 8'h18;
    localparam logic [7:0] ADDR_LBB   = 8'h1A;

    localparam logic [7:0]  RST_BLINK = 8'h00;
    localparam logic [15:0] RST_FS0   = 16'h002C;
    localparam logic [15:0] RST_FS1   = 16'h0023;
    localparam logic [15:0] RST_PSEL  = 16'h0000;
    localparam logic [15:0] RST_EN    = 16'h000F;
    localparam logic [15:0] RST_LB    = 16'h0000;
    localparam int RATE_LSB = 0;
    localparam int RATE_W   = 3;

    // function bit positions inside a port's status word
    localparam int F_DPX    = 0;
    localparam int F_COL    = 1;
    localparam int F_LNK    = 2;
    localparam int F_ACT    = 3;
    localparam int F_SPD10  = 4;
    localparam int F_SPD100 = 5;
    localparam int F_PHY4   = 6;

    typedef enum logic [1:0] {
        LB_AUTO  = 2'b00,
        LB_BLINK = 2'b01,
        LB_ON    = 2'b10,
        LB_OFF   = 2'b11
    } psl_light_e;

    localparam logic [1:0] DM_A = 2'b11;
    localparam logic [1:0] DM_B = 2'b10;
    localparam logic [1:0] DM_C = 2'b01;
    localparam logic [1:0] DM_D = 2'b00;

    localparam logic [3:0] DFLT_MASK_WIDE   = 4'h7;
    localparam logic [3:0] DFLT_MASK_NARROW = 4'h4;

    localparam int CLK_HZ        = 40_000_000;
    localparam int BLINK_BASE_MS = 25;
    localparam int BLINK_BASE_CYC = BLINK_BASE_MS * (CLK_HZ / 1000);
    localparam int SER_HALF_NS   = 100;
    localparam int SER_HALF_CYC  = (SER_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int FRAME_GAP_HALVES = 8;
endpackage

// >>> core/psl_stream_if.sv
// status stream carried from the indicator core to the serialiser
`timescale 1ns/10ps
interface psl_stream_if;
    logic [psl_pkg::STREAM_W-1:0] val;
    logic [psl_pkg::STREAM_W-1:0] mask;
    modport src  (output val, output mask);
    modport sink (input val, input mask);
endinterface

// >>> core/psl_serial_shifter.sv
// serial indicator shifter for external shift registers
`timescale 1ns/10ps
module psl_serial_shifter #(
    parameter int NBITS    = psl_pkg::STREAM_W,
    parameter int HALF_CYC = psl_pkg::SER_HALF_CYC
) (
    input  wire logic  clock_in,
    input  wire logic  rst_n_in,
    psl_stream_if.sink strm,
    output logic       data_out,
    output logic       shift_clk_out
);
    localparam int IDX_W = $clog2(NBITS);

    if (HALF_CYC < 1 || NBITS < 2) begin : g_bad_cfg
        $error("bad shifter params");
    end

    typedef enum logic [2:0] {
        SH_LOAD = 3'b000,
        SH_FIND = 3'b001,
        SH_LOW  = 3'b011,
        SH_HIGH = 3'b010,
        SH_GAP  = 3'b110
    } psl_shift_e;

    psl_shift_e       state;
    logic [NBITS-1:0] bits_q;
    logic [NBITS-1:0] mask_q;
    logic [IDX_W-1:0] idx;
    logic [IDX_W:0]   hit;
    logic [15:0]      half_cnt;
    logic             tick;
    logic [7:0]       gap_cnt;

    // highest selected slot at or below from, top bit flags a hit;
    // one-cycle search keeps in-frame pauses well under the frame gap
    function automatic logic [IDX_W:0] next_sel(
        input logic [NBITS-1:0] m,
        input logic [IDX_W-1:0] from
    );
        logic [IDX_W:0] r;
        r = '0;
        for (int i = 0; i < NBITS; i++) begin
            if (m[i] && i <= int'(from)) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    assign hit = next_sel(mask_q, idx);

    //------------------------------------------------------------
    // half bit divider
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || half_cnt == 16'(HALF_CYC - 1)) begin
            half_cnt <= '0;
        end else begin
            half_cnt <= half_cnt + 16'h0001;
        end
    end
    assign tick = (half_cnt == 16'(HALF_CYC - 1));

    //------------------------------------------------------------
    // frame sequencer
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state         <= SH_LOAD;
            bits_q        <= '0;
            mask_q        <= '0;
            idx           <= '0;
            gap_cnt       <= '0;
            data_out      <= 1'b1;
            shift_clk_out <= 1'b0;
        end else begin
            unique case (state)
                SH_LOAD: begin
                    bits_q <= strm.val;
                    mask_q <= strm.mask;
                    idx    <= '1;
                    state  <= SH_FIND;
                end
                SH_FIND: begin
                    // unselected slots cost no clock edge
                    if (hit[IDX_W]) begin
                        idx      <= hit[IDX_W-1:0];
                        data_out <= ~bits_q[hit[IDX_W-1:0]];
                        state    <= SH_LOW;
                    end else begin
                        data_out <= 1'b1;
                        gap_cnt  <= '0;
                        state    <= SH_GAP;
                    end
                end
                SH_LOW: begin
                    if (tick) begin
                        shift_clk_out <= 1'b1;
                        state         <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (tick) begin
                        shift_clk_out <= 1'b0;
                        if (idx == '0) begin
                            data_out <= 1'b1;
                            gap_cnt  <= '0;
                            state    <= SH_GAP;
                        end else begin
                            idx   <= idx - 1'b1;
                            state <= SH_FIND;
                        end
                    end
                end
                SH_GAP: begin
                    // quiet gap lets the far side latch the frame
                    if (tick) begin
                        gap_cnt <= gap_cnt + 8'h01;
                        if (gap_cnt == 8'(psl_pkg::FRAME_GAP_HALVES - 1)) begin
                            state <= SH_LOAD;
                        end
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    rise_selected_a: assert property (
        $rose(shift_clk_out)
        |-> mask_q[idx] && data_out == ~bits_q[idx])
        else $error("shift clock on unselected or wrong bit");
    gap_quiet_a: assert property (
        state == SH_GAP |-> data_out && !shift_clk_out)
        else $error("serial line not idle in gap");
endmodule

// >>> core/psl_led_driver.sv
// port status indicator driver: parallel pins and serial feed
`timescale 1ns/10ps
module psl_led_driver #(
    parameter int BLINK_BASE_CYCLES = psl_pkg::BLINK_BASE_CYC,
    parameter int SER_HALF_CYCLES   = psl_pkg::SER_HALF_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic [1:0]  default_display_strap_in,
    input  wire logic        display_count_strap_in,
    input  wire logic        port5_data_used_in,
    input  wire logic        use_registers_in,
    input  wire logic [63:0] port_status_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] led_in,
    output logic      [15:0] led_out,
    output logic      [15:0] led_oe_out,
    output logic      [15:0] reg_rdata_out,
    output logic             serial_indicator_out,
    output logic             serial_indicator_shift_clk_out
);
    localparam int NP = psl_pkg::NUM_PORTS;
    localparam int NF = psl_pkg::NUM_FUNCS;

    // counts below one would stall the dividers for good
    if (BLINK_BASE_CYCLES < 1 || SER_HALF_CYCLES < 1) begin : g_bad_cfg
        $error("cycle counts must be at least one");
    end


    //------------------------------------------------------------
    // pin and strap synchronisers
    //------------------------------------------------------------
    logic [15:0] led_s1;
    logic [15:0] led_s2;
    logic [4:0]  strap_s1;
    logic [4:0]  strap_s2;

    always_ff @(posedge clock_in) begin
        led_s1   <= led_in;
        led_s2   <= led_s1;
        strap_s1 <= {use_registers_in, port5_data_used_in,
                     display_count_strap_in, default_display_strap_in};
        strap_s2 <= strap_s1;
    end

    //------------------------------------------------------------
    // strap capture after reset release
    //------------------------------------------------------------
    logic                           strap_done;
    logic [psl_pkg::STRAP_PINS-1:0] pol;
    logic [1:0]                     dflt_mode;
    logic                           count_strap;
    logic                           port5_used;
    logic                           eight_mode;

    // pins are released during reset, so the pulls set the level
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            strap_done  <= 1'b0;
            pol         <= '0;
            dflt_mode   <= psl_pkg::DM_D;
            count_strap <= 1'b0;
            port5_used  <= 1'b0;
        end else if (!strap_done) begin
            strap_done  <= 1'b1;
            pol         <= led_s2[psl_pkg::STRAP_PINS-1:0];
            dflt_mode   <= strap_s2[1:0];
            count_strap <= strap_s2[2];
            port5_used  <= strap_s2[3];
        end
    end
    assign eight_mode = port5_used || !count_strap;

    //------------------------------------------------------------
    // register file
    //------------------------------------------------------------
    logic [7:0]  blink_rate_ctl;
    logic [15:0] function_set_zero;
    logic [15:0] function_set_one;
    logic [15:0] port_function_select;
    logic [15:0] port_display_enable;
    logic [15:0] lighting_behaviour_a;
    logic [15:0] lighting_behaviour_b;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            blink_rate_ctl       <= psl_pkg::RST_BLINK;
            function_set_zero    <= psl_pkg::RST_FS0;
            function_set_one     <= psl_pkg::RST_FS1;
            port_function_select <= psl_pkg::RST_PSEL;
            port_display_enable  <= psl_pkg::RST_EN;
            lighting_behaviour_a <= psl_pkg::RST_LB;
            lighting_behaviour_b <= psl_pkg::RST_LB;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                psl_pkg::ADDR_BLINK: blink_rate_ctl <= reg_wdata_in[7:0];
                psl_pkg::ADDR_FS0:   function_set_zero <= reg_wdata_in;
                psl_pkg::ADDR_FS1:   function_set_one <= reg_wdata_in;
                psl_pkg::ADDR_PSEL:  port_function_select <= reg_wdata_in;
                psl_pkg::ADDR_EN:    port_display_enable <= reg_wdata_in;
                psl_pkg::ADDR_LBA:   lighting_behaviour_a <= reg_wdata_in;
                psl_pkg::ADDR_LBB:   lighting_behaviour_b <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                psl_pkg::ADDR_BLINK: reg_rdata_out <= {8'h00, blink_rate_ctl};
                psl_pkg::ADDR_FS0:   reg_rdata_out <= function_set_zero;
                psl_pkg::ADDR_FS1:   reg_rdata_out <= function_set_one;
                psl_pkg::ADDR_PSEL:  reg_rdata_out <= port_function_select;
                psl_pkg::ADDR_EN:    reg_rdata_out <= port_display_enable;
                psl_pkg::ADDR_LBA:   reg_rdata_out <= lighting_behaviour_a;
                psl_pkg::ADDR_LBB:   reg_rdata_out <= lighting_behaviour_b;
                default:             reg_rdata_out <= 16'h0000;
            endcase
        end
    end

    //------------------------------------------------------------
    // blink divider
    //------------------------------------------------------------
    logic [31:0] blink_cnt;
    logic [31:0] blink_limit;
    logic        blink_ph;
    logic [2:0]  rate;

    assign rate = blink_rate_ctl[psl_pkg::RATE_LSB +: psl_pkg::RATE_W];
    // slower rates stretch the base half period by rate plus one
    assign blink_limit = 32'(BLINK_BASE_CYCLES) * (32'(rate) + 32'h1)
                         - 32'h1;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            blink_cnt <= '0;
            blink_ph  <= 1'b0;
        end else if (blink_cnt >= blink_limit) begin
            blink_cnt <= '0;
            blink_ph  <= ~blink_ph;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    //------------------------------------------------------------
    // status stream
    //------------------------------------------------------------
    function automatic logic light(input logic [1:0] code,
                                   input logic st, input logic act,
                                   input logic ph);
        logic r;
        r = st;
        unique case (code)
            psl_pkg::LB_AUTO:  r = act ? (st & ph) : st;
            psl_pkg::LB_BLINK: r = st & ph;
            psl_pkg::LB_ON:    r = 1'b1;
            psl_pkg::LB_OFF:   r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] dflt_rows(input logic [1:0] m,
                                             input logic [15:0] s,
                                             input logic ph);
        logic [3:0] r;
        logic       a;
        a = s[psl_pkg::F_ACT] & ph;
        r = 4'h0;
        unique case (m)
            psl_pkg::DM_A: r = {1'b0, s[psl_pkg::F_SPD100] & ~a,
                                s[psl_pkg::F_SPD10] & ~a, s[psl_pkg::F_DPX]};
            psl_pkg::DM_B: r = {1'b0, s[psl_pkg::F_SPD100],
                                s[psl_pkg::F_LNK] & ~a, s[psl_pkg::F_DPX]};
            psl_pkg::DM_C: r = {1'b0, (s[psl_pkg::F_SPD10] |
                                s[psl_pkg::F_SPD100]) & ~a,
                                s[psl_pkg::F_DPX] ^ (s[psl_pkg::F_COL] & ph),
                                s[psl_pkg::F_PHY4]};
            psl_pkg::DM_D: r = {1'b0, s[psl_pkg::F_SPD100],
                                s[psl_pkg::F_LNK] & ~a, s[psl_pkg::F_PHY4]};
        endcase
        return r;
    endfunction

    // first selected functions fill the pins, lower bit on lower pin
    function automatic logic [3:0] pack_pins(input logic [15:0] m,
                                             input logic [15:0] v,
                                             input logic narrow);
        logic [3:0] r;
        logic [2:0] n;
        r = 4'h0;
        n = 3'h0;
        for (int i = 0; i < 16; i++) begin
            if (m[i] && n < (narrow ? 3'h2 : 3'h4)) begin
                r[n[1:0]] = v[i];
                n = n + 3'h1;
            end
        end
        return r;
    endfunction

    logic [NF-1:0]        val [NP];
    logic [NF-1:0]        sel [NP];
    logic [3:0]           prow [NP];
    logic [15:0]          pin_on;
    logic [15:0]          pin_used;
    logic [15:0]          pol_eff;
    psl_stream_if         strm ();

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            logic [NF-1:0] st;
            logic [3:0]    dr;
            assign st = port_status_in[gp*NF +: NF];
            assign sel[gp] = port_function_select[gp] ? function_set_one
                                                      : function_set_zero;
            assign dr = dflt_rows(dflt_mode, st, blink_ph);
            for (genvar gf = 0; gf < NF; gf++) begin : g_fn
                assign val[gp][gf] = port_display_enable[gp] & light(
                    {lighting_behaviour_b[gf], lighting_behaviour_a[gf]},
                    st[gf], gf == psl_pkg::F_ACT, blink_ph);
            end
            // one stream feeds both the pins and the serialiser
            always_comb begin
                if (strap_s2[4]) begin
                    prow[gp] = pack_pins(sel[gp], val[gp], eight_mode);
                    strm.val[gp*NF +: NF]  = val[gp];
                    strm.mask[gp*NF +: NF] = port_display_enable[gp] ?
                                             sel[gp] : 16'h0000;
                end else begin
                    prow[gp] = port_display_enable[gp] ?
                               (eight_mode ? {2'b00, dr[3], dr[2]} : dr)
                               : 4'h0;
                    strm.val[gp*NF +: NF]  = {12'h000, prow[gp]};
                    strm.mask[gp*NF +: NF] = !port_display_enable[gp] ?
                        16'h0000 : {12'h000, eight_mode ?
                        psl_pkg::DFLT_MASK_NARROW : psl_pkg::DFLT_MASK_WIDE};
                end
            end
        end
    endgenerate

    //------------------------------------------------------------
    // pin map and polarity
    //------------------------------------------------------------
    always_comb begin
        pin_on   = 16'h0000;
        pin_used = 16'h0000;
        for (int p = 0; p < NP; p++) begin
            if (eight_mode) begin
                pin_on[2*p +: 2]   = prow[p][1:0];
                pin_used[2*p +: 2] = 2'b11;
            end else begin
                pin_on[4*p +: 4]   = prow[p];
                pin_used[4*p +: 4] = 4'hF;
            end
        end
        pol_eff = {6'h3F, pol};
        if (eight_mode) begin
            pol_eff[15:8] = 8'h00;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            led_out    <= 16'h0000;
            led_oe_out <= 16'h0000;
        end else if (strap_done) begin
            led_out    <= ~(pin_on ^ pol_eff);
            led_oe_out <= pin_used;
        end
    end

    psl_serial_shifter #(
        .NBITS    (psl_pkg::STREAM_W),
        .HALF_CYC (SER_HALF_CYCLES)
    ) u_shift (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .strm          (strm),
        .data_out      (serial_indicator_out),
        .shift_clk_out (serial_indicator_shift_clk_out)
    );

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    narrow_forced_a: assert property (
        strap_done && port5_used |=> led_oe_out[15:8] == 8'h00)
        else $error("port 5 use did not force eight outputs");
    high_pins_a: assert property (
        strap_done && !eight_mode
        |=> led_out[15:10] == $past(pin_on[15:10]))
        else $error("high pins not active high");
    strap_latch_a: assert property (
        $rose(strap_done)
        |-> pol == $past(led_s2[psl_pkg::STRAP_PINS-1:0]))
        else $error("polarity not taken from strap level");
    port_dark_a: assert property (
        strap_done && !port_display_enable[0]
        |=> led_out[0] == ~$past(pol_eff[0]))
        else $error("disabled port lit");
    forced_on_a: assert property (
        port_display_enable[1] && lighting_behaviour_b[2]
        && !lighting_behaviour_a[2] |-> val[1][2])
        else $error("on mode not active");
    blink_span_a: assert property (
        $changed(blink_ph)
        |-> $past(blink_cnt) >= $past(blink_limit))
        else $error("blink phase moved early");
endmodule

// >>> dv/psl_shift_model.sv
// serial-in shift register model on the far side of the serial feed
`timescale 1ns/10ps
module psl_shift_model (
    input  wire logic        clock_in,
    input  wire logic        data_in,
    input  wire logic        shift_clk_in,
    output logic      [15:0] word_out,
    output logic      [4:0]  nbits_out,
    output int               frames_out
);
    logic [15:0] sr;
    logic [4:0]  n;
    logic        clk_d;
    int          quiet;
    initial begin
        {sr, n, clk_d, quiet} = '0;
        {word_out, nbits_out, frames_out} = '0;
    end
    always @(posedge clock_in) begin
        clk_d <= shift_clk_in;
        quiet <= shift_clk_in ? 0 : quiet + 1;
        if (shift_clk_in && !clk_d) begin
            sr <= {sr[14:0], data_in};
            n  <= n + 5'h01;
        end
        // longer than any in-frame pause, shorter than the frame gap
        if (quiet == 28 && n != 5'h00) begin
            word_out   <= sr;
            nbits_out  <= n;
            frames_out <= frames_out + 1;
            sr         <= 16'h0000;
            n          <= 5'h00;
        end
    end
endmodule

// >>> dv/psl_led_driver_test.sv
// self-checking bench for the port status indicator driver
`timescale 1ns/10ps
module psl_led_driver_test;
    typedef struct packed {
        logic        u;
        logic [15:0] en;
        logic [63:0] st;
    } psl_row_s;
    localparam logic [63:0] SA = 64'h0005_0001_0004_0020;
    localparam logic [63:0] SB = 64'h0020_0025_0000_0005;
    localparam logic [15:0] STRAP = 16'h02A5;
    // pins above the strap range are active high whatever their pull
    localparam logic [15:0] POL = 16'hFC00 | STRAP;
    localparam psl_row_s ROWS [6] = '{
        '{1'b1, 16'h000F, SA}, '{1'b1, 16'h0003, SB},
        '{1'b1, 16'h001C, SA}, '{1'b1, 16'h000D, SB},
        '{1'b0, 16'h000F, SB}, '{1'b0, 16'h000F, SA}};
    localparam logic [7:0] RA [8] = '{8'h0F, 8'h10, 8'h12, 8'h14,
                                     8'h16, 8'h18, 8'h1A, 8'h11};
    localparam logic [15:0] RV [8] = '{16'h0000, psl_pkg::RST_FS0,
        psl_pkg::RST_FS1, psl_pkg::RST_PSEL, psl_pkg::RST_EN,
        psl_pkg::RST_LB, psl_pkg::RST_LB, 16'h0000};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        p5 = 1'b0;
    logic        usereg = 1'b1;
    logic        cnt16 = 1'b1;
    logic [1:0]  dmode = 2'b10;
    logic [63:0] status = '0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] led_in, led_out, led_oe, rdata, word;
    logic        sdata, sclk, prev;
    logic [4:0]  nbits;
    int          frames, n;
    int          err_total = 0;
    int          checks_done = 0;
    psl_row_s    r;
    assign led_in = (led_oe & led_out) | (~led_oe & STRAP);
    always #12.5 clk = ~clk;
    psl_led_driver #(.BLINK_BASE_CYCLES(8), .SER_HALF_CYCLES(4))
    psl_led_driver_i (
        .clock_in(clk), .rst_n_in(rst_n),
        .default_display_strap_in(dmode), .display_count_strap_in(cnt16),
        .port5_data_used_in(p5), .use_registers_in(usereg),
        .port_status_in(status), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
        .led_in(led_in), .led_out(led_out), .led_oe_out(led_oe),
        .reg_rdata_out(rdata), .serial_indicator_out(sdata),
        .serial_indicator_shift_clk_out(sclk));
    psl_shift_model psl_shift_model_i (
        .clock_in(clk), .data_in(sdata), .shift_clk_in(sclk),
        .word_out(word), .nbits_out(nbits), .frames_out(frames));
    function automatic logic [15:0] exp_par(logic u, logic [3:0] en,
                                            logic [63:0] st);
        logic [15:0] on;
        on = 16'h0000;
        for (int p = 0; p < 4; p++) begin
            if (en[p]) begin
                on[4*p]   = st[16*p];
                on[4*p+1] = st[16*p+2];
                on[4*p+2] = !u & st[16*p+5];
            end
        end
        return on ^ ~POL;
    endfunction
    function automatic logic [15:0] exp_ser(logic [3:0] en,
                                            logic [63:0] st);
        logic [15:0] w;
        w = 16'h0000;
        for (int p = 3; p >= 0; p--) begin
            if (en[p]) w = {w[13:0], ~st[16*p+2], ~st[16*p]};
        end
        return w;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic wait_frames(input int k);
        int f0;
        int t;
        f0 = frames;
        t = 0;
        while (frames < f0 + k && t < 3000) begin
            @(negedge clk);
            t++;
        end
        chk(frames >= f0 + k, 1);
    endtask
    initial begin
        #750000;
        err_total++;
        give_verdict();
    end
    initial begin
        do_reset();
        wr(8'h10, 16'h0005);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            usereg = r.u;
            status = r.st;
            wr(8'h16, r.en);
            wait_frames(2);
            chk(led_out, exp_par(r.u, r.en[3:0], r.st));
            chk(led_oe, 16'hFFFF);
            if (r.u) begin
                chk(nbits, 2 * $countones(r.en[3:0]));
                chk(word, exp_ser(r.en[3:0], r.st));
            end
        end
        status = 64'h0001_0001_0001_0001;
        usereg = 1'b1;
        wr(8'h0F, 16'hFFFF);
        rdc(8'h0F, 16'h00FF);
        wr(8'h1A, 16'h0004);
        chk(led_out[5], POL[5]);
        wr(8'h1A, 16'h0000);
        wr(8'h12, 16'h0004);
        wr(8'h14, 16'h0001);
        chk({led_out[4], led_out[0]}, {POL[4], ~POL[0]});
        wr(8'h14, 16'h0000);
        wr(8'h0F, 16'h0002);
        wr(8'h18, 16'h0001);
        n = 0;
        prev = led_out[4];
        repeat (240) begin
            @(negedge clk);
            if (led_out[4] !== prev) n++;
            prev = led_out[4];
        end
        chk(n >= 9 && n <= 11, 1);
        p5 = 1'b1;
        status = 64'h0000_0000_0000_0004;
        do_reset();
        chk(led_oe[15:8], 8'h00);
        chk({led_out[2], led_out[0]}, {~POL[2], POL[0]});
        wr(8'h11, 16'hFFFF);
        for (int i = 0; i < 8; i++) rdc(RA[i], RV[i]);
        p5 = 1'b0;
        cnt16 = 1'b0;
        dmode = 2'b01;
        usereg = 1'b0;
        status = 64'h0000_0000_0000_0010;
        do_reset();
        chk({led_oe, led_out[1:0]}, {16'h00FF, ~POL[1], POL[0]});
        give_verdict();
    end
endmodule
